/* File: rtl/fcais_pkg.sv */
// shared constants, range codes and carrier types for the four channel input scaler
package fcais_pkg;
	// ==========================================================
	// channel count and data widths
	localparam int NUM_CH      = 4;      // converted inputs
	localparam int CH_W        = 2;      // channel index width
	localparam int DATA_W      = 16;     // result word width
	localparam int AVG_DEPTH   = 8;      // samples in the moving average
	localparam int AVG_SHIFT   = 3;      // log2 of the average depth
	localparam int SW_W        = 10;     // configuration switch count
	localparam int CODE_W      = 3;      // range code width

	// ==========================================================
	// timing
	localparam int CLK_PERIOD_NS = 100;        // 10 MHz unit clock
	localparam int POINT_TIME_NS = 1_000_000;  // one point refreshed per ms
	localparam int POINT_CYCLES  = (POINT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SETTLE_CYCLES = 3;          // switch synchroniser fill time

	// ==========================================================
	// switch positions (index 0 is switch 1)
	localparam int SW_PAIR0_LO = 0;   // switches 1..3, read as (sw1,sw2,sw3)
	localparam int SW_PAIR1_LO = 3;   // switches 4..6
	localparam int SW_AVG      = 6;   // switch 7
	localparam int SW_SOFT     = 9;   // switch 10

	// ==========================================================
	// range codes, bit2 = first switch of the group
	localparam logic [2:0] RNG_0_5V   = 3'h0;
	localparam logic [2:0] RNG_1_5V   = 3'h4;
	localparam logic [2:0] RNG_0_10V  = 3'h2;
	localparam logic [2:0] RNG_BIP10V = 3'h6;
	localparam logic [2:0] RNG_4_20MA = 3'h1;
	localparam logic [2:0] RNG_0_20MA = 3'h5;

	// ==========================================================
	// scaled limits (signed result counts)
	localparam logic signed [31:0] BIP_EXT_LO  = -32'sd3300;  // 16'hF31C
	localparam logic signed [31:0] BIP_EXT_HI  = 32'sd3300;   // 16'h0CE4
	localparam logic signed [31:0] UNI_EXT_LO  = -32'sd300;   // 16'hFED4
	localparam logic signed [31:0] UNI_EXT_HI  = 32'sd6300;   // 16'h189C
	localparam logic [15:0]        OPEN_FLAG   = 16'h7FFF;    // open-circuit marker
	localparam logic signed [31:0] OPEN_MV     = 32'sd800;    // 0.8 V in mV
	localparam logic signed [31:0] OPEN_UA     = 32'sd3200;   // 3.2 mA in uA

	// ==========================================================
	// apb register map (byte offsets)
	localparam logic [7:0] OFS_RESULT0 = 8'h00;  // results 0..3 at 00,04,08,0C
	localparam logic [7:0] OFS_RANGE   = 8'h10;  // software ranges, 3 bits per channel
	localparam logic [7:0] OFS_STATUS  = 8'h14;  // switch snapshot and channel flags
	localparam logic [11:0] RANGE_RESET = 12'h000;  // all channels 0-5 V
	localparam int ST_READY_LO = 16;   // ready flags
	localparam int ST_OPEN_LO  = 20;   // open-circuit flags
	localparam int ST_BAD_LO   = 24;   // invalid range flags

	// ==========================================================
	// carrier types
	typedef struct packed {
		logic [CH_W-1:0]          chan;  // channel converted
		logic signed [DATA_W-1:0] raw;   // mV or uA, signed
	} fcais_sample_t;

	typedef struct packed {
		logic              ready;  // first result available
		logic              open;   // open-circuit forced
		logic [DATA_W-1:0] data;   // result word
	} fcais_result_t;
endpackage

/* File: rtl/fcais_top.sv */
// four channel analog input scaler with switch/apb range control and averaging
// Summary of operation
// RULE1 - switch ranges apply per input pair
// RULE2 - switches 1-3 code range of inputs 0,1
// RULE3 - switches 4-6 code range of inputs 2,3
// RULE4 - switches 8 and 9 kept off
// RULE5 - switch 10 selects switch or software ranges
// RULE6 - software ranges default to 0-5 V
// RULE7 - software range held per channel
// RULE8 - results clamp at extended range limits
// RULE9 - bipolar maps F448..0BB8, clamps F31C..0CE4
// RULE10 - unipolar maps 0000..1770, clamps FED4..189C
// RULE11 - negatives are 16-bit two's complement
// RULE12 - open line reads zero on plain ranges
// RULE13 - live-zero under threshold forces 7FFF
// RULE14 - open check every conversion, self-clearing; with averaging on, a channel's first seven conversions are not checked
// RULE15 - switch 7 enables averaging on all
// RULE16 - average of last eight conversions
// RULE17 - no result until eight samples averaged
// RULE18 - one ms per point regardless averaging
// RULE19 - all four channels every 4 ms
// RULE20 - switches sampled only after reset
module fcais_top
	import fcais_pkg::*;
#(
	parameter int POINT_CYC = fcais_pkg::POINT_CYCLES  // cycles per conversion slot
) (
	input  wire logic                    pclk,
	input  wire logic                    presetn,
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [7:0]              paddr,
	input  wire logic [31:0]             pwdata,
	output logic                         pready,
	output logic [31:0]                  prdata,
	output logic                         pslverr,
	input  wire logic [fcais_pkg::SW_W-1:0] dip_sw,
	output logic                         conv_req,
	output logic [fcais_pkg::CH_W-1:0]   conv_chan,
	input  wire logic                    adc_valid,
	input  wire fcais_pkg::fcais_sample_t adc_sample,
	output fcais_pkg::fcais_result_t     result [fcais_pkg::NUM_CH]
);
	import fcais_pkg::*;

	// ==========================================================
	// functions
	// scale a raw reading for a range code, already clamped
	function automatic logic signed [31:0] scale_clamp(input logic [2:0] code,
		input logic signed [15:0] raw);
		logic signed [31:0] x;
		logic signed [31:0] v;
		logic signed [31:0] lo;
		logic signed [31:0] hi;
		x  = 32'(raw);
		lo = UNI_EXT_LO;
		hi = UNI_EXT_HI;
		case (code)
			RNG_0_5V:   v = (x * 6) / 5;             // 5000 mV -> 6000
			RNG_1_5V:   v = ((x - 1000) * 3) / 2;    // 4000 mV span
			RNG_0_10V:  v = (x * 3) / 5;             // 10000 mV -> 6000
			RNG_BIP10V: begin
				v  = (x * 3) / 10;                  // +-10000 mV -> +-3000 [RULE9]
				lo = BIP_EXT_LO;
				hi = BIP_EXT_HI;
			end
			RNG_4_20MA: v = ((x - 4000) * 3) / 8;    // 16000 uA span [RULE10]
			RNG_0_20MA: v = (x * 3) / 10;            // 20000 uA -> 6000
			default:    v = 32'sd0;                  // invalid code reads zero
		endcase
		// clamp at the extended data limits
		if (v < lo) begin
			v = lo;  // [RULE8]
		end else if (v > hi) begin
			v = hi;  // [RULE8]
		end
		return v;
	endfunction

	// live-zero ranges only; plain ranges fall to zero naturally [RULE12]
	function automatic logic open_check(input logic [2:0] code,
		input logic signed [15:0] raw);
		logic signed [31:0] x;
		x = 32'(raw);
		case (code)
			RNG_1_5V:   return x < OPEN_MV;  // [RULE13]
			RNG_4_20MA: return x < OPEN_UA;  // [RULE13]
			default:    return 1'b0;
		endcase
	endfunction

	function automatic logic code_ok(input logic [2:0] code);
		case (code)
			RNG_0_5V, RNG_1_5V, RNG_0_10V, RNG_BIP10V, RNG_4_20MA, RNG_0_20MA: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction

	// ==========================================================
	// switch synchroniser and one-time capture
	logic [SW_W-1:0] sw_meta_reg;    // first stage, read only by stage two
	logic [SW_W-1:0] sw_s2_reg;      // second stage
	logic [SW_W-1:0] sw_s3_reg;      // third stage
	logic [SW_W-1:0] sw_cfg_reg;     // frozen snapshot
	logic            cfg_done_reg;   // snapshot taken
	logic [1:0]      settle_reg;     // synchroniser fill count

	// three stages; a change counts once stages two and three agree
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sw_meta_reg <= '0;
			sw_s2_reg   <= '0;
			sw_s3_reg   <= '0;
		end else begin
			sw_meta_reg <= dip_sw;
			sw_s2_reg   <= sw_meta_reg;
			sw_s3_reg   <= sw_s2_reg;
		end
	end

	// switches move only with power off, so one snapshot after reset suffices
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			settle_reg   <= '0;
			cfg_done_reg <= 1'b0;
			sw_cfg_reg   <= '0;
		end else if (!cfg_done_reg) begin
			if (settle_reg != 2'(SETTLE_CYCLES)) begin
				settle_reg <= settle_reg + 2'd1;
			end else if (sw_s2_reg == sw_s3_reg) begin
				sw_cfg_reg   <= sw_s3_reg;  // [RULE20]
				cfg_done_reg <= 1'b1;       // [RULE20]
			end
		end
	end

	// ==========================================================
	// range selection
	logic [11:0] soft_range_reg;       // software range, one field per channel
	logic [2:0]  ch_code [NUM_CH];     // effective code per channel
	logic        soft_mode;            // switch 10 on
	logic        avg_en;               // switch 7 on

	assign soft_mode = sw_cfg_reg[SW_SOFT];  // [RULE5]
	assign avg_en    = sw_cfg_reg[SW_AVG];   // [RULE15]

	// pair codes from switches, or per-channel codes from software
	always_comb begin
		for (int c = 0; c < NUM_CH; c++) begin
			if (soft_mode) begin
				ch_code[c] = soft_range_reg[3*c +: 3];  // [RULE7]
			end else if (c < 2) begin
				// (sw1,sw2,sw3) with sw1 as the top bit [RULE1] [RULE2]
				ch_code[c] = {sw_cfg_reg[SW_PAIR0_LO], sw_cfg_reg[SW_PAIR0_LO+1],
					sw_cfg_reg[SW_PAIR0_LO+2]};
			end else begin
				// same table on switches 4..6 [RULE1] [RULE3]
				ch_code[c] = {sw_cfg_reg[SW_PAIR1_LO], sw_cfg_reg[SW_PAIR1_LO+1],
					sw_cfg_reg[SW_PAIR1_LO+2]};
			end
		end
	end

	// ==========================================================
	// conversion scheduler: one point per slot, four slots per sweep
	typedef enum logic [1:0] {ST_WAIT_CFG, ST_RUN} fcais_sched_t;
	fcais_sched_t   state_reg;     // scheduler state
	logic [31:0]    slot_cnt_reg;  // cycles within the current slot
	logic [CH_W-1:0] chan_reg;     // channel of the latest request
	logic            req_reg;      // request pulse

	// requests stay at fixed pace, averaging adds no delay [RULE18] [RULE19]
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg    <= ST_WAIT_CFG;
			slot_cnt_reg <= '0;
			chan_reg     <= '1;  // so the first request names channel 0
			req_reg      <= 1'b0;
		end else begin
			req_reg <= 1'b0;
			case (state_reg)
				ST_WAIT_CFG: begin
					if (cfg_done_reg) begin
						state_reg    <= ST_RUN;
						slot_cnt_reg <= 32'(POINT_CYC - 1);
					end
				end
				ST_RUN: begin
					if (slot_cnt_reg == 32'(POINT_CYC - 1)) begin
						slot_cnt_reg <= '0;
						req_reg      <= 1'b1;               // [RULE19]
						chan_reg     <= chan_reg + 2'd1;    // wraps after channel 3
					end else begin
						slot_cnt_reg <= slot_cnt_reg + 32'd1;
					end
				end
				default: state_reg <= ST_WAIT_CFG;
			endcase
		end
	end

	assign conv_req  = req_reg;
	assign conv_chan = chan_reg;  // straight from the flip-flop, held until the next pulse

	// ==========================================================
	// per-sample processing
	logic [15:0]  hist_reg [NUM_CH][AVG_DEPTH];  // last eight scaled values
	logic [2:0]   wr_idx_reg [NUM_CH];           // next history slot
	logic [3:0]   fill_reg [NUM_CH];             // samples taken, saturates at 8
	logic         in_chan_ok;                    // sample chan
	logic [2:0]   in_code;                       // range of the sampled channel
	logic signed [31:0] in_scaled;               // scaled and clamped
	logic         in_open;                       // open-circuit now
	logic signed [31:0] in_sum;                  // history sum with new value
	logic [15:0]  in_avg;                        // average word

	assign in_chan_ok = 1'b1;
	assign in_code    = ch_code[adc_sample.chan];
	assign in_scaled  = scale_clamp(in_code, adc_sample.raw);
	assign in_open    = open_check(in_code, adc_sample.raw);

	// sum of the eight most recent values, the new one replacing the oldest
	always_comb begin
		in_sum = 32'sd0;
		for (int k = 0; k < AVG_DEPTH; k++) begin
			if (3'(k) == wr_idx_reg[adc_sample.chan]) begin
				in_sum = in_sum + in_scaled;
			end else begin
				in_sum = in_sum + 32'(signed'(hist_reg[adc_sample.chan][k]));
			end
		end
		in_avg = 16'(in_sum >>> AVG_SHIFT);  // [RULE16]
	end

	// history ring and fill count
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int c = 0; c < NUM_CH; c++) begin
				wr_idx_reg[c] <= '0;
				fill_reg[c]   <= '0;
				for (int k = 0; k < AVG_DEPTH; k++) begin
					hist_reg[c][k] <= '0;
				end
			end
		end else if (adc_valid && in_chan_ok) begin
			hist_reg[adc_sample.chan][wr_idx_reg[adc_sample.chan]] <= 16'(in_scaled);
			wr_idx_reg[adc_sample.chan] <= wr_idx_reg[adc_sample.chan] + 3'd1;
			if (fill_reg[adc_sample.chan] != 4'(AVG_DEPTH)) begin
				fill_reg[adc_sample.chan] <= fill_reg[adc_sample.chan] + 4'd1;
			end
		end
	end

	// result words, refreshed on each conversion of the channel once it is ready (eighth sample on with averaging)
	fcais_result_t res_reg [NUM_CH];  // held results
	logic          in_ready;          // this sample makes the channel ready

	assign in_ready = !avg_en || (fill_reg[adc_sample.chan] >= 4'(AVG_DEPTH - 1));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int c = 0; c < NUM_CH; c++) begin
				res_reg[c] <= '0;
			end
		end else if (adc_valid && in_ready) begin
			// open flag follows every conversion once the channel is ready and clears itself [RULE14]
			res_reg[adc_sample.chan].open  <= in_open;
			res_reg[adc_sample.chan].ready <= 1'b1;  // [RULE17]
			if (in_open) begin
				res_reg[adc_sample.chan].data <= OPEN_FLAG;  // [RULE13]
			end else if (avg_en) begin
				res_reg[adc_sample.chan].data <= in_avg;  // [RULE15] [RULE16]
			end else begin
				// low 16 bits of the signed value are its two's complement [RULE11]
				res_reg[adc_sample.chan].data <= 16'(in_scaled);
			end
		end
	end

	assign result = res_reg;

	// ==========================================================
	// apb slave, zero wait states
	logic       wr_en;      // write access phase
	logic       addr_hit;   // mapped address
	logic [3:0] bad_code;   // invalid range per channel

	assign pready   = 1'b1;
	assign wr_en    = psel && penable && pwrite;
	assign addr_hit = (paddr[1:0] == 2'b00) && (paddr <= OFS_STATUS);
	assign pslverr  = psel && penable && !addr_hit;

	always_comb begin
		for (int c = 0; c < NUM_CH; c++) begin
			bad_code[c] = !code_ok(ch_code[c]);
		end
	end

	// software range register; only meaningful once switch 10 is on [RULE6]
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			soft_range_reg <= RANGE_RESET;  // [RULE6]
		end else if (wr_en && paddr == OFS_RANGE) begin
			soft_range_reg <= pwdata[11:0];  // [RULE7]
		end
	end

	// read mux; unmapped words read zero with pslverr
	always_comb begin
		prdata = '0;
		if (paddr < OFS_RANGE && paddr[1:0] == 2'b00) begin
			prdata = {16'h0000, res_reg[paddr[3:2]].data};
		end else if (paddr == OFS_RANGE) begin
			prdata = {20'h0_0000, soft_range_reg};
		end else if (paddr == OFS_STATUS) begin
			prdata[SW_W-1:0] = sw_cfg_reg;
			for (int c = 0; c < NUM_CH; c++) begin
				prdata[ST_READY_LO + c] = res_reg[c].ready;
				prdata[ST_OPEN_LO + c]  = res_reg[c].open;
				prdata[ST_BAD_LO + c]   = bad_code[c];
			end
		end
	end

	// ==========================================================
	// assertions
	property p_snapshot_frozen;
		@(posedge pclk) disable iff (!presetn)
		cfg_done_reg |=> $stable(sw_cfg_reg);
	endproperty
	a_snapshot_frozen: assert property (p_snapshot_frozen)  // [RULE20]
		else $error("switch snapshot changed after capture");

	property p_pair_share;
		@(posedge pclk) disable iff (!presetn)
		!soft_mode |-> (ch_code[0] == ch_code[1]) && (ch_code[2] == ch_code[3]);
	endproperty
	a_pair_share: assert property (p_pair_share)  // [RULE1]
		else $error("pair channels got different switch ranges");

	property p_pair0_code;
		@(posedge pclk) disable iff (!presetn)
		!soft_mode |-> ch_code[0] == {sw_cfg_reg[0], sw_cfg_reg[1], sw_cfg_reg[2]};
	endproperty
	a_pair0_code: assert property (p_pair0_code)  // [RULE2]
		else $error("inputs 0,1 range not from switches 1-3");

	property p_pair1_code;
		@(posedge pclk) disable iff (!presetn)
		!soft_mode |-> ch_code[2] == {sw_cfg_reg[3], sw_cfg_reg[4], sw_cfg_reg[5]};
	endproperty
	a_pair1_code: assert property (p_pair1_code)  // [RULE3]
		else $error("inputs 2,3 range not from switches 4-6");

	property p_soft_code;
		@(posedge pclk) disable iff (!presetn)
		soft_mode |-> ch_code[3] == soft_range_reg[11:9];
	endproperty
	a_soft_code: assert property (p_soft_code)  // [RULE5]
		else $error("software range not used with switch 10 on");

	property p_open_flag;
		@(posedge pclk) disable iff (!presetn)
		adc_valid && in_ready && in_open |=> res_reg[$past(adc_sample.chan)].data == 16'h7FFF;
	endproperty
	a_open_flag: assert property (p_open_flag)  // [RULE13]
		else $error("open circuit did not force 7FFF");

	property p_open_clear;
		@(posedge pclk) disable iff (!presetn)
		adc_valid && in_ready && !in_open |=> !res_reg[$past(adc_sample.chan)].open;
	endproperty
	a_open_clear: assert property (p_open_clear)  // [RULE14]
		else $error("open flag not cleared by good conversion");

	property p_clamp;
		@(posedge pclk) disable iff (!presetn)
		adc_valid |-> (in_scaled >= BIP_EXT_LO) && (in_scaled <= UNI_EXT_HI)
			&& (in_code != RNG_BIP10V || in_scaled <= BIP_EXT_HI)
			&& (in_code == RNG_BIP10V || in_scaled >= UNI_EXT_LO);
	endproperty
	a_clamp: assert property (p_clamp)  // [RULE8]
		else $error("scaled value outside extended range");

	property p_avg_wait;
		@(posedge pclk) disable iff (!presetn)
		avg_en && adc_valid && fill_reg[adc_sample.chan] < 4'd7
			|=> !res_reg[$past(adc_sample.chan)].ready || $past(res_reg[adc_sample.chan].ready);
	endproperty
	a_avg_wait: assert property (p_avg_wait)  // [RULE17]
		else $error("averaged result before eight samples");

	property p_slot_pace;
		@(posedge pclk) disable iff (!presetn)
		conv_req |=> !conv_req [*8];
	endproperty
	a_slot_pace: assert property (p_slot_pace)  // [RULE18]
		else $error("conversion requests too close together");
endmodule

/* File: test/fcais_conv_model.sv */
// converter model: answers each conversion request with that channel's level
module fcais_conv_model
	import fcais_pkg::*;
(
	input  wire logic                       pclk,
	input  wire logic                       presetn,
	input  wire logic                       conv_req,
	input  wire logic [fcais_pkg::CH_W-1:0] conv_chan,
	input  wire logic signed [15:0]         lvl [fcais_pkg::NUM_CH],
	input  wire logic [3:0]                 lag,
	output logic                            adc_valid,
	output fcais_pkg::fcais_sample_t        adc_sample
);
	timeunit 1ns;
	timeprecision 1ns;
	import fcais_pkg::*;
	// ==========================================================
	// request tracking
	logic [3:0]      wait_reg;  // cycles left before the answer
	logic            busy_reg;  // a conversion is in flight
	logic [CH_W-1:0] chan_reg;  // channel being converted

	// answer lag+1 cycles after the request; outside an answer the data lines toggle
	// so a design that samples them late never sees a stale match
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_reg   <= 1'b0;
			wait_reg   <= 4'h0;
			chan_reg   <= '0;
			adc_valid  <= 1'b0;
			adc_sample <= '0;
		end else begin
			adc_valid  <= 1'b0;
			adc_sample <= ~adc_sample;
			if (conv_req) begin
				busy_reg <= 1'b1;
				wait_reg <= lag;
				chan_reg <= conv_chan;
			end else if (busy_reg && wait_reg == 4'h0) begin
				busy_reg   <= 1'b0;
				adc_valid  <= 1'b1;
				adc_sample <= {chan_reg, lvl[chan_reg]};
			end else if (busy_reg) begin
				wait_reg <= wait_reg - 4'h1;
			end
		end
	end
endmodule

/* File: test/test_four_ch_analog_input_scaling.sv */
// self-checking bench for the four channel input scaler
module test_four_ch_analog_input_scaling
	import fcais_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	// ==========================================================
	// signals and bench state
	localparam int PC = 20;  // shortened conversion slot
	logic               pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic [7:0]         paddr;
	logic [31:0]        pwdata, prdata, rd;
	logic [31:0]        seed = 32'h0000_29dd;  // fixed random start
	logic [SW_W-1:0]    dip_sw;
	logic               conv_req, adc_valid, chk_en, avg, seen, opn;
	logic [CH_W-1:0]    conv_chan, last_ch;
	fcais_sample_t      adc_sample;
	fcais_result_t      result [NUM_CH];
	logic signed [15:0] lvl [NUM_CH];
	logic [3:0]         lag;
	logic [2:0]         rng [NUM_CH];  // range the bench believes each channel has
	logic [2:0]         cd [7] = '{RNG_0_5V, RNG_1_5V, RNG_0_10V, RNG_BIP10V,
		RNG_4_20MA, RNG_0_20MA, 3'h3};
	int                 hist [NUM_CH][$];  // clamped history per channel
	int                 exp_dat [NUM_CH];
	int                 miscompares, samples_checked, cyc, gap, ch, v, s;

	fcais_top #(.POINT_CYC(PC)) fcais_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .dip_sw(dip_sw), .conv_req(conv_req),
		.conv_chan(conv_chan), .adc_valid(adc_valid), .adc_sample(adc_sample), .result(result));
	fcais_conv_model fcais_conv_model_i (.pclk(pclk), .presetn(presetn), .conv_req(conv_req),
		.conv_chan(conv_chan), .lvl(lvl), .lag(lag), .adc_valid(adc_valid),
		.adc_sample(adc_sample));

	always #50 pclk = ~pclk;

	// ==========================================================
	// helpers
	function automatic logic [31:0] rnd();
		seed = seed[0] ? (seed >> 1) ^ 32'h8020_0003 : seed >> 1;
		return seed;
	endfunction

	// without averaging, corners near thresholds and clamps, else wide random levels; with averaging, narrower random levels only
	function automatic int pick();
		int cn [10] = '{0, 799, 800, 1000, 3199, 3200, 4000, 20000, -12000, 5000};
		logic [31:0] r;
		r = rnd();
		if (avg) return int'($signed(r[28:16]));
		if (r[3:0] < 4'ha) return cn[r[3:0]];
		return 2 * int'($signed(r[29:16]));
	endfunction

	function automatic int scale(logic [2:0] c, int r);
		int x;
		case (c)
			RNG_0_5V:   x = r * 6 / 5;
			RNG_1_5V:   x = (r - 1000) * 3 / 2;
			RNG_0_10V:  x = r * 3 / 5;
			RNG_4_20MA: x = (r - 4000) * 3 / 8;
			default:    x = r * 3 / 10;  // bipolar and 0-20 mA share the factor
		endcase
		if (c == RNG_BIP10V) return x < BIP_EXT_LO ? BIP_EXT_LO : x > BIP_EXT_HI ? BIP_EXT_HI : x;
		return x < UNI_EXT_LO ? UNI_EXT_LO : x > UNI_EXT_HI ? UNI_EXT_HI : x;
	endfunction

	// switch word, first switch of a group is the code's top bit
	function automatic logic [SW_W-1:0] mk_sw(logic [2:0] a, logic [2:0] b, logic g, logic f);
		return {f, 2'b00, g, b[0], b[1], b[2], a[0], a[1], a[2]};
	endfunction

	task automatic chk_word(logic [31:0] got, logic [31:0] want);
		samples_checked++;
		if (got !== want) begin
			miscompares++;
			$display("[ERR] %0t got %h want %h", $time, got, want);
		end
	endtask

	task automatic end_sim();
		if (miscompares == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// one apb transfer, request held until pready is seen high
	task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic do_reset(logic [SW_W-1:0] sw);
		@(posedge pclk);
		presetn <= 1'b0;
		dip_sw <= sw;
		repeat (16) @(posedge pclk);
		for (int k = 0; k < NUM_CH; k++) hist[k].delete();
		presetn <= 1'b1;
		chk_en = 1'b1;
	endtask

	// sweeps with fresh levels and a fresh converter lag each time
	task automatic run(int n);
		repeat (n) begin
			@(posedge pclk);
			lag <= 4'(rnd() % 7);
			for (int k = 0; k < NUM_CH; k++) lvl[k] <= 16'(pick());
			repeat (4 * PC) @(posedge pclk);
		end
	endtask

	// ==========================================================
	// result monitor: expectation from the sample the converter handed in
	always @(posedge pclk) begin
		if (presetn === 1'b1 && adc_valid === 1'b1) begin
			ch = int'(adc_sample.chan);
			v = scale(rng[ch], int'(adc_sample.raw));
			opn = (rng[ch] == RNG_1_5V && adc_sample.raw < 800) ||
				(rng[ch] == RNG_4_20MA && adc_sample.raw < 3200);
			hist[ch].push_back(v);
			if (hist[ch].size() > AVG_DEPTH) void'(hist[ch].pop_front());
			s = 0;
			for (int k = 0; k < hist[ch].size(); k++) s += hist[ch][k];
			exp_dat[ch] = (rng[ch] inside {3'h3, 3'h7}) ? 0 : opn ? int'(OPEN_FLAG) : !avg ? v :
				hist[ch].size() == AVG_DEPTH ? s >>> AVG_SHIFT : 0;
			#1;
			if (chk_en) begin
				chk_word(32'(result[ch].data), 32'(exp_dat[ch][15:0]));
				if (!(rng[ch] inside {3'h3, 3'h7})) begin
					chk_word(32'(result[ch].open), 32'(opn));
					chk_word(32'(result[ch].ready), 32'(!avg || hist[ch].size() == AVG_DEPTH));
				end
			end
		end
	end

	// request spacing and channel order, plus the hang limit
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			end_sim();
		end else if (presetn !== 1'b1) begin
			seen = 1'b0;
		end else if (conv_req === 1'b1) begin
			if (seen) chk_word(gap, PC);
			if (seen) chk_word(32'(conv_chan), 32'(2'(last_ch + 2'd1)));
			seen = 1'b1;
			last_ch = conv_chan;
			gap = 1;
		end else begin
			gap++;
		end
	end

	// ==========================================================
	// main sequence
	initial begin
		pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
		dip_sw = 0; lag = 0; lvl = '{default: 16'h0000}; avg = 0; chk_en = 0;
		for (int i = 0; i < 7; i++) begin
			@(negedge pclk);
			chk_en = 0;
			rng = '{cd[i], cd[i], cd[(i + 3) % 7], cd[(i + 3) % 7]};
			do_reset(mk_sw(cd[i], cd[(i + 3) % 7], 1'b0, 1'b0));
			run(6);
		end
		dip_sw <= mk_sw(RNG_BIP10V, RNG_1_5V, 1'b1, 1'b1);
		run(2);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk_word(32'(rd[9:0]), 32'(mk_sw(cd[6], cd[2], 1'b0, 1'b0)));
		chk_word(32'(rd[31:16]), 32'h0000_030F);
		@(negedge pclk);
		chk_en = 0;
		rng = '{default: RNG_0_5V};
		do_reset(mk_sw(RNG_BIP10V, RNG_4_20MA, 1'b0, 1'b1));
		apb(1'b0, OFS_RANGE, 32'h0);
		chk_word(32'(rd[11:0]), 32'(RANGE_RESET));
		run(3);
		@(negedge pclk);
		chk_en = 0;
		apb(1'b1, OFS_RANGE, {20'h0_0000, RNG_1_5V, RNG_4_20MA, RNG_BIP10V, RNG_0_10V});
		@(negedge pclk);
		rng = '{RNG_0_10V, RNG_BIP10V, RNG_4_20MA, RNG_1_5V};
		run(2);
		chk_en = 1;
		run(6);
		repeat (10) @(posedge pclk);
		for (int k = 0; k < NUM_CH; k++) begin
			// start just after a sample so no update lands inside the read
			@(posedge pclk iff adc_valid === 1'b1);
			apb(1'b0, 8'(4 * k), 32'h0);
			chk_word(32'(rd[15:0]), 32'(exp_dat[k][15:0]));
		end
		apb(1'b0, 8'h18, 32'h0);
		chk_word(32'(er), 32'h0000_0001);
		@(negedge pclk);
		chk_en = 0;
		avg = 1;
		rng = '{RNG_0_5V, RNG_0_5V, RNG_BIP10V, RNG_BIP10V};
		do_reset(mk_sw(RNG_0_5V, RNG_BIP10V, 1'b1, 1'b0));
		run(12);
		end_sim();
	end
endmodule
